/* lpmc_map.svh */
// Constants of the low-power mode controller.
// Assumes inclusion by the package and both ends; it holds definitions only.
// ********
// Notes on behaviour
// ********
// Notes on behaviour
// - Three low-power modes, steered by self-control bits.
// - Every mode exit causes internal reset, then calibration; the code skips both going from software suspend into a hardware mode.
// - Calibration end sets init-done, clears serial-busy.
// - Host leaves registers alone for about 10 ms.
// - Standby powers down all but the receiver.
// - In standby, link activity drives the LED low.
// - Standby ignores every host bus access.
// - Standby needs request pin low, both enables.
// - Standby entry resets all but self-control.
// - Request pin high ends standby, full reset follows.
// - Hardware suspend isolates core, ignores bus, network.
// - Suspend needs request low, lowpower set, select clear.
// - Request pin high ends suspend, full reset follows.
// - Software suspend keeps only base, self-control registers; the code resets the base register at wake too.
// - Setting bit 8 enters software suspend.
// - Any host write wakes; data discarded, reset follows.
// - External hardware reset leaves any low-power mode.
// - Hardware modes beat software suspend.
// - Transmit, receive, collision drive the LED low.
// - LED stays low until 6 ms idle.
`ifndef LPMC_MAP_SVH
`define LPMC_MAP_SVH
// ********
// Device register map (8-bit register address, 16-bit data)
// ********
`define LPMC_IOBASE_ADDR   8'h20
`define LPMC_SELF_CONTROL_REG_ADDR  8'h0F
`define LPMC_SELFST_ADDR   8'h10
`define LPMC_SOFT_SUSP_BIT 8
`define LPMC_HW_LP_BIT     9
`define LPMC_STBY_SEL_BIT  10
`define LPMC_INIT_DONE_BIT 7
`define LPMC_SI_BUSY_BIT   8
`define LPMC_SELF_CONTROL_REG_MASK  16'h0700
`define LPMC_SELF_CONTROL_REG_RST   16'h0000
`define LPMC_IOBASE_RST    16'h0300
// ********
// Host controller registers on AXI4-Lite (byte addresses)
// ********
`define LPMC_H_CTRL_ADDR   8'h00
`define LPMC_H_CMD_ADDR    8'h04
`define LPMC_H_STAT_ADDR   8'h08
`define LPMC_H_SLEEP_BIT   0
`define LPMC_H_RD_BIT      24
`define LPMC_H_BUSY_BIT    16
`define LPMC_H_TMO_BIT     17
`define LPMC_H_LED_BIT     18
`define LPMC_RESP_OKAY     2'h0
`define LPMC_RESP_SLVERR   2'h2
// ********
// Timing
// ********
`define LPMC_CLK_HZ        100000000
`define LPMC_CAL_TIME_MS   10
`define LPMC_LED_TIME_MS   6
`define LPMC_RD_TMO_CYC    8'h40
`endif

/* lpmc_pkg.sv */
// Types shared by both ends of the low-power mode controller.
// Assumes lpmc_map.svh is on the include path.
`include "lpmc_map.svh"
package lpmc_pkg;
    // Operating modes of the device end.
    typedef enum logic [2:0] {
        LPMC_INIT,
        LPMC_RUN,
        LPMC_HW_STANDBY,
        LPMC_HW_SUSPEND,
        LPMC_SW_SUSPEND
    } lpmc_mode_t;
endpackage

/* lpmc_if.sv */
// Link between the host controller and the power-managed device.
// Assumes both ends run on the same aclk; it carries no clock itself.
`timescale 1ns/1ns
interface lpmc_if;
    logic        low_power_request_n;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_addr;
    logic [15:0] io_wdata;
    logic [15:0] io_rdata;
    logic        io_rvalid;
    logic        activity_led_n;
    modport dev (input low_power_request_n, io_wr, io_rd, io_addr, io_wdata,
                 output io_rdata, io_rvalid, activity_led_n);
    modport host (output low_power_request_n, io_wr, io_rd, io_addr, io_wdata,
                  input io_rdata, io_rvalid, activity_led_n);
endinterface

/* lpmc_device.sv */
// Device end: mode sequencer, register slice, reset and calibration, activity LED.
// Assumes host strobes are one-cycle pulses synchronous to aclk; the request pin is not.
`timescale 1ns/1ns
`include "lpmc_map.svh"
module lpmc_device
    import lpmc_pkg::*;
#(
    parameter int unsigned CAL_CYCLES = `LPMC_CAL_TIME_MS * (`LPMC_CLK_HZ / 1000),
    parameter int unsigned LED_CYCLES = `LPMC_LED_TIME_MS * (`LPMC_CLK_HZ / 1000)
) (
    input  wire logic   aclk,
    input  wire logic   aresetn,
    lpmc_if.dev         link,
    input  wire logic   tx_event,
    input  wire logic   rx_event,
    input  wire logic   col_event,
    input  wire logic   link_activity,
    output logic        core_reset,
    output logic        analog_on,
    output logic        rx_listen,
    output logic        core_isolate,
    output lpmc_mode_t  mode
);
    // ********
    // State
    // ********
    typedef struct packed {
        lpmc_mode_t  mode;
        logic        sleep_meta;
        logic        sleep_sync;
        logic [15:0] self_control_reg;
        logic [15:0] iobase;
        logic        init_done;
        logic        si_busy;
        logic [19:0] cal_cnt;
        logic [19:0] led_cnt;
        logic        led_n;
        logic [15:0] rdata;
        logic        rvalid;
        logic        core_reset;
        logic        analog_on;
        logic        rx_listen;
        logic        isolate;
    } lpmc_dev_state_t;

    // External reset lands in calibration, the same as any internal reset.
    localparam lpmc_dev_state_t RST_STATE = '{
        mode:       LPMC_INIT,
        sleep_meta: 1'b1,
        sleep_sync: 1'b1,
        self_control_reg:    `LPMC_SELF_CONTROL_REG_RST,
        iobase:     `LPMC_IOBASE_RST,
        si_busy:    1'b1,
        cal_cnt:    20'(CAL_CYCLES),
        led_n:      1'b1,
        core_reset: 1'b1,
        analog_on:  1'b1,
        rx_listen:  1'b1,
        default:    '0
    };

    lpmc_dev_state_t q;
    lpmc_dev_state_t d;
    logic            hw_req;
    logic            event_any;

    // Address decode shared by the write and the read paths.
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    // ********
    // Next state
    // ********
    always_comb begin
        d = q;
        // Only the second stage is looked at by the mode logic.
        d.sleep_meta = link.low_power_request_n;
        d.sleep_sync = q.sleep_meta;
        d.rvalid     = 1'b0;
        d.core_reset = 1'b0;
        hw_req    = !q.sleep_sync && q.self_control_reg[`LPMC_HW_LP_BIT];
        event_any = tx_event || rx_event || col_event;
        case (q.mode)
            LPMC_RUN, LPMC_INIT: begin
                // Accesses are served during calibration; software is expected to wait.
                if (link.io_wr) begin
                    if (addr_is(link.io_addr, `LPMC_SELF_CONTROL_REG_ADDR)) begin
                        d.self_control_reg = link.io_wdata & `LPMC_SELF_CONTROL_REG_MASK;
                    end
                    if (addr_is(link.io_addr, `LPMC_IOBASE_ADDR)) begin
                        d.iobase = link.io_wdata;
                    end
                end
                if (link.io_rd) begin
                    d.rvalid = 1'b1;
                    d.rdata  = 16'h0000;
                    if (addr_is(link.io_addr, `LPMC_SELF_CONTROL_REG_ADDR)) begin
                        d.rdata = q.self_control_reg;
                    end
                    if (addr_is(link.io_addr, `LPMC_IOBASE_ADDR)) begin
                        d.rdata = q.iobase;
                    end
                    if (addr_is(link.io_addr, `LPMC_SELFST_ADDR)) begin
                        d.rdata[`LPMC_INIT_DONE_BIT] = q.init_done;
                        d.rdata[`LPMC_SI_BUSY_BIT]   = q.si_busy;
                    end
                end
                if (q.mode == LPMC_INIT) begin
                    if (q.cal_cnt == 20'h00000) begin
                        d.mode      = LPMC_RUN;
                        d.init_done = 1'b1;
                        d.si_busy   = 1'b0;
                    end else begin
                        d.cal_cnt = q.cal_cnt - 20'h00001;
                    end
                end else if (hw_req) begin
                    // Hardware request is tested first, so it wins over bit 8.
                    d.mode = q.self_control_reg[`LPMC_STBY_SEL_BIT] ? LPMC_HW_STANDBY
                                                           : LPMC_HW_SUSPEND;
                end else if (q.self_control_reg[`LPMC_SOFT_SUSP_BIT]) begin
                    d.mode = LPMC_SW_SUSPEND;
                end
            end
            LPMC_SW_SUSPEND: begin
                if (hw_req) begin
                    d.mode = q.self_control_reg[`LPMC_STBY_SEL_BIT] ? LPMC_HW_STANDBY
                                                           : LPMC_HW_SUSPEND;
                end else if (link.io_wr) begin
                    // The waking write only wakes; its data never reaches a register.
                    d.mode = LPMC_INIT;
                end
            end
            LPMC_HW_STANDBY, LPMC_HW_SUSPEND: begin
                // Bus strobes are not looked at here at all.
                if (q.sleep_sync) begin
                    d.mode = LPMC_INIT;
                end
            end
            default: begin
                d.mode = LPMC_INIT;
            end
        endcase
        // Entry to a hardware mode clears everything but the self-control register.
        if ((d.mode == LPMC_HW_STANDBY || d.mode == LPMC_HW_SUSPEND)
            && q.mode != d.mode) begin
            d.iobase    = `LPMC_IOBASE_RST;
            d.init_done = 1'b0;
            d.si_busy   = 1'b0;
            d.rdata     = 16'h0000;
        end
        // Every return to INIT starts a full reset and a fresh calibration.
        if (d.mode == LPMC_INIT && q.mode != LPMC_INIT) begin
            d.core_reset = 1'b1;
            d.cal_cnt    = 20'(CAL_CYCLES);
            d.init_done  = 1'b0;
            d.si_busy    = 1'b1;
            d.iobase     = `LPMC_IOBASE_RST;
            // Clearing the suspend bit keeps the device from falling straight back asleep.
            d.self_control_reg[`LPMC_SOFT_SUSP_BIT] = 1'b0;
        end
        // Power domains follow the next mode, so outputs match the mode register.
        d.analog_on = (d.mode == LPMC_RUN || d.mode == LPMC_INIT);
        d.rx_listen = d.analog_on || d.mode == LPMC_HW_STANDBY;
        d.isolate   = (d.mode == LPMC_HW_SUSPEND);
        // Activity LED: stretched in run and calibration, raw link sense in standby, dark otherwise.
        if (d.analog_on) begin
            if (event_any) begin
                d.led_cnt = 20'(LED_CYCLES);
            end else if (q.led_cnt != 20'h00000) begin
                d.led_cnt = q.led_cnt - 20'h00001;
            end
            d.led_n = (d.led_cnt == 20'h00000);
        end else if (d.mode == LPMC_HW_STANDBY) begin
            d.led_cnt = 20'h00000;
            d.led_n   = !link_activity;
        end else begin
            d.led_cnt = 20'h00000;
            d.led_n   = 1'b1;
        end
    end

    // ********
    // Registers
    // ********
    // Synchronous reset any mode returns to calibration.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= RST_STATE;
        end else begin
            q <= d;
        end
    end

    assign link.io_rdata       = q.rdata;
    assign link.io_rvalid      = q.rvalid;
    assign link.activity_led_n = q.led_n;
    assign core_reset          = q.core_reset;
    assign analog_on           = q.analog_on;
    assign rx_listen           = q.rx_listen;
    assign core_isolate        = q.isolate;
    assign mode                = q.mode;
endmodule // lpmc_device

/* lpmc_host.sv */
// Host end: AXI4-Lite slave holding the controller's registers, driving the device link.
// Assumes the device answers reads one cycle after the strobe, or never while asleep.
`timescale 1ns/1ns
`include "lpmc_map.svh"
module lpmc_host
    import lpmc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    lpmc_if.host             link,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // ********
    // State
    // ********
    typedef struct packed {
        logic        awready;
        logic        awgot;
        logic [7:0]  awaddr;
        logic        wready;
        logic        wgot;
        logic [31:0] wdata;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        sleep_req;
        logic        io_wr;
        logic        io_rd;
        logic [7:0]  io_addr;
        logic [15:0] io_wdata;
        logic        busy;
        logic [7:0]  tmo;
        logic [15:0] rd_data;
        logic        rd_tmo;
    } lpmc_host_state_t;

    lpmc_host_state_t q;
    lpmc_host_state_t d;

    // ********
    // Next state
    // ********
    always_comb begin
        d = q;
        d.io_wr = 1'b0;
        d.io_rd = 1'b0;
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_awvalid && q.awready) begin
            d.awgot  = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.wgot  = 1'b1;
            d.wdata = s_axi_wdata;
        end
        // Write executes once both halves are held; the response follows next cycle.
        if (q.awgot && q.wgot && !q.bvalid) begin
            d.awgot  = 1'b0;
            d.wgot   = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = `LPMC_RESP_OKAY;
            if (q.awaddr == `LPMC_H_CTRL_ADDR) begin
                d.sleep_req = q.wdata[`LPMC_H_SLEEP_BIT];
            end else if (q.awaddr == `LPMC_H_CMD_ADDR) begin
                // A command while a read is pending is dropped; software polls busy.
                if (!q.busy) begin
                    d.io_addr  = q.wdata[23:16];
                    d.io_wdata = q.wdata[15:0];
                    d.io_rd    = q.wdata[`LPMC_H_RD_BIT];
                    d.io_wr    = !q.wdata[`LPMC_H_RD_BIT];
                    d.busy     = q.wdata[`LPMC_H_RD_BIT];
                    d.tmo      = `LPMC_RD_TMO_CYC;
                    d.rd_tmo   = 1'b0;
                end
            end else if (q.awaddr != `LPMC_H_STAT_ADDR) begin
                d.bresp = `LPMC_RESP_SLVERR;
            end
        end
        // A sleeping device never answers, so a pending read times out.
        if (q.busy) begin
            if (link.io_rvalid) begin
                d.busy    = 1'b0;
                d.rd_data = link.io_rdata;
            end else if (q.tmo == 8'h00) begin
                d.busy   = 1'b0;
                d.rd_tmo = 1'b1;
            end else begin
                d.tmo = q.tmo - 8'h01;
            end
        end
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp  = `LPMC_RESP_OKAY;
            d.rdata  = 32'h00000000;
            case (s_axi_araddr)
                `LPMC_H_CTRL_ADDR: d.rdata[`LPMC_H_SLEEP_BIT] = q.sleep_req;
                `LPMC_H_CMD_ADDR: d.rdata = {7'h00, q.io_rd, q.io_addr, q.io_wdata};
                `LPMC_H_STAT_ADDR: begin
                    d.rdata[15:0]             = q.rd_data;
                    d.rdata[`LPMC_H_BUSY_BIT] = q.busy;
                    d.rdata[`LPMC_H_TMO_BIT]  = q.rd_tmo;
                    d.rdata[`LPMC_H_LED_BIT]  = !link.activity_led_n;
                end
                default: d.rresp = `LPMC_RESP_SLVERR;
            endcase
        end
        d.awready = !d.awgot && !d.bvalid;
        d.wready  = !d.wgot && !d.bvalid;
        d.arready = !d.rvalid;
    end

    // ********
    // Registers
    // ********
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign link.low_power_request_n = !q.sleep_req;
    assign link.io_wr               = q.io_wr;
    assign link.io_rd               = q.io_rd;
    assign link.io_addr             = q.io_addr;
    assign link.io_wdata            = q.io_wdata;
    assign s_axi_awready            = q.awready;
    assign s_axi_wready             = q.wready;
    assign s_axi_bresp              = q.bresp;
    assign s_axi_bvalid             = q.bvalid;
    assign s_axi_arready            = q.arready;
    assign s_axi_rdata              = q.rdata;
    assign s_axi_rresp              = q.rresp;
    assign s_axi_rvalid             = q.rvalid;
endmodule // lpmc_host

/* lpmc_properties.sv */
// Concurrent checks on the link between the host end and the device end.
// Assumes it sits beside the lpmc_if instance and sees the device mode and events.
`timescale 1ns/1ns
module lpmc_properties
    import lpmc_pkg::*;
#(
    parameter int unsigned LED_CYCLES = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic low_power_request_n,
    input wire logic io_rd,
    input wire logic io_rvalid,
    input wire logic activity_led_n,
    input wire logic link_activity,
    input wire logic tx_event,
    input wire logic rx_event,
    input wire logic col_event,
    input wire logic core_reset,
    input lpmc_mode_t mode
);
    // ********
    // Clocking and helper counters
    // ********
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [15:0] idle_q;
    logic        seen_q;
    // Idle cycles since the last event; cleared outside RUN so a mode exit starts clean.
    always_ff @(posedge aclk) begin
        if (!aresetn || mode != LPMC_RUN) begin
            idle_q <= 16'h0000;
            seen_q <= 1'b0;
        end else if (tx_event || rx_event || col_event) begin
            idle_q <= 16'h0000;
            seen_q <= 1'b1;
        end else if (idle_q != 16'hFFFF) begin
            idle_q <= idle_q + 16'h0001;
        end
    end
    // Read answers only where the device is awake; one cycle of slack on the LED figures.
    a_rvalid_cause: assert property (io_rvalid |-> $past(io_rd) &&
        ($past(mode) == LPMC_RUN || $past(mode) == LPMC_INIT)) else $error("unrequested answer");
    a_standby_deaf: assert property (mode == LPMC_HW_STANDBY && io_rd |=> !io_rvalid)
        else $error("standby answered a read");
    a_suspend_deaf: assert property (mode == LPMC_HW_SUSPEND && io_rd |=> !io_rvalid)
        else $error("suspend answered a read");
    a_soft_no_read: assert property (mode == LPMC_SW_SUSPEND && io_rd |=> !io_rvalid)
        else $error("soft suspend answered a read");
    a_standby_led: assert property (mode == LPMC_HW_STANDBY && $past(mode) == LPMC_HW_STANDBY
        |-> activity_led_n == !$past(link_activity)) else $error("standby led wrong");
    a_suspend_dark: assert property (mode == LPMC_HW_SUSPEND &&
        $past(mode) == LPMC_HW_SUSPEND |-> activity_led_n) else $error("suspend led lit");
    a_event_led: assert property ((tx_event || rx_event || col_event) && mode == LPMC_RUN
        |=> mode != LPMC_RUN || !activity_led_n) else $error("event did not light led");
    a_led_hold: assert property (seen_q && idle_q < LED_CYCLES - 1 && mode == LPMC_RUN
        |-> !activity_led_n) else $error("led released early");
    a_led_release: assert property (seen_q && idle_q == LED_CYCLES + 1 && mode == LPMC_RUN
        |-> activity_led_n) else $error("led held too long");
    a_standby_entry: assert property (mode == LPMC_HW_STANDBY &&
        $past(mode) != LPMC_HW_STANDBY |-> !$past(low_power_request_n, 3))
        else $error("standby without request");
    a_suspend_entry: assert property (mode == LPMC_HW_SUSPEND &&
        $past(mode) != LPMC_HW_SUSPEND |-> !$past(low_power_request_n, 3))
        else $error("suspend without request");
    a_hw_exit_reset: assert property (($past(mode) == LPMC_HW_STANDBY ||
        $past(mode) == LPMC_HW_SUSPEND) && mode != $past(mode)
        |-> mode == LPMC_INIT ##[0:2] core_reset) else $error("hardware exit without reset");
    a_soft_exit: assert property ($past(mode) == LPMC_SW_SUSPEND && mode != $past(mode)
        |-> mode != LPMC_RUN) else $error("soft exit skipped init");
endmodule // lpmc_properties

/* tb_low_power_mode_controller.sv */
// Self-checking bench: host end and device end joined by lpmc_if, driven over AXI4-Lite.
// Assumes the package, map header and both design ends are compiled first.
`timescale 1ns/1ns
`include "lpmc_map.svh"
module tb_low_power_mode_controller
    import lpmc_pkg::*;
;
    localparam int unsigned CAL = 20;
    localparam int unsigned LED = 10;
    logic        aclk, aresetn, link_activity, core_reset, analog_on, rx_listen, core_isolate;
    logic [2:0]  ev;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, s;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    lpmc_mode_t  mode;
    int          error_cnt, num_checks;
    lpmc_if link ();
    lpmc_device #(.CAL_CYCLES(CAL), .LED_CYCLES(LED)) lpmc_device_i (.aclk, .aresetn,
        .link(link), .tx_event(ev[0]), .rx_event(ev[1]), .col_event(ev[2]), .link_activity,
        .core_reset, .analog_on, .rx_listen, .core_isolate, .mode);
    lpmc_host lpmc_host_i (.aclk, .aresetn, .link(link), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    lpmc_properties #(.LED_CYCLES(LED)) lpmc_properties_i (.aclk, .aresetn,
        .low_power_request_n(link.low_power_request_n), .io_rd(link.io_rd),
        .io_rvalid(link.io_rvalid), .activity_led_n(link.activity_led_n), .link_activity,
        .tx_event(ev[0]), .rx_event(ev[1]), .col_event(ev[2]), .core_reset, .mode);
    // ********
    // Clock, compare and bus tasks
    // ********
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Address and data are offered together and each is dropped at its own handshake.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // One device access through the command register, then status polled until idle.
    task automatic dev(input logic rd, input logic [7:0] a, input logic [15:0] d,
                       output logic [31:0] st);
        logic [1:0] rr;
        int         n;
        axi_wr(`LPMC_H_CMD_ADDR, {7'h00, rd, a, d});
        n = 0;
        do begin
            axi_rd(`LPMC_H_STAT_ADDR, st, rr);
            n++;
        end while (st[`LPMC_H_BUSY_BIT] !== 1'b0 && n < 200);
        if (n == 200) error_cnt++;
    endtask
    task automatic wait_mode(input lpmc_mode_t m);
        int n;
        n = 0;
        while (mode !== m && n < 500) begin
            @(posedge aclk);
            n++;
        end
        chk(32'(mode), 32'(m));
    endtask
    // ********
    // Main sequence
    // ********
    initial begin
        {aresetn, link_activity, ev, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        error_cnt = 0;
        num_checks = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        wait_mode(LPMC_RUN);
        dev(1'b1, `LPMC_SELFST_ADDR, 16'h0000, s);
        chk(32'(s[`LPMC_SI_BUSY_BIT:`LPMC_INIT_DONE_BIT]), 32'h1);
        axi_rd(8'h0C, s, r);
        chk(32'(r), 32'(`LPMC_RESP_SLVERR));
        axi_wr(8'h0C, 32'h0);
        chk(32'(r), 32'(`LPMC_RESP_SLVERR));
        // Standby: the receiver keeps listening while bus reads go unanswered.
        dev(1'b0, `LPMC_SELF_CONTROL_REG_ADDR, 16'h0600, s);
        axi_wr(`LPMC_H_CTRL_ADDR, 32'h1);
        wait_mode(LPMC_HW_STANDBY);
        chk(32'({analog_on, rx_listen}), 32'h1);
        link_activity <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(32'(link.activity_led_n), 32'h0);
        link_activity <= 1'b0;
        dev(1'b1, `LPMC_SELFST_ADDR, 16'h0000, s);
        chk(32'(s[`LPMC_H_TMO_BIT]), 32'h1);
        axi_wr(`LPMC_H_CTRL_ADDR, 32'h0);
        wait_mode(LPMC_INIT);
        wait_mode(LPMC_RUN);
        dev(1'b1, `LPMC_SELF_CONTROL_REG_ADDR, 16'h0000, s);
        chk(32'(s[15:0]), 32'h0600);
        // Hardware suspend: core isolated, a transmit event leaves the LED dark.
        dev(1'b0, `LPMC_SELF_CONTROL_REG_ADDR, 16'h0200, s);
        axi_wr(`LPMC_H_CTRL_ADDR, 32'h1);
        wait_mode(LPMC_HW_SUSPEND);
        chk(32'(core_isolate), 32'h1);
        ev <= 3'b001;
        @(posedge aclk);
        ev <= 3'b000;
        repeat (2) @(posedge aclk);
        chk(32'(link.activity_led_n), 32'h1);
        axi_wr(`LPMC_H_CTRL_ADDR, 32'h0);
        wait_mode(LPMC_INIT);
        wait_mode(LPMC_RUN);
        // Software suspend: reads refused, a write wakes and its data is dropped.
        dev(1'b0, `LPMC_SELF_CONTROL_REG_ADDR, 16'h0100, s);
        wait_mode(LPMC_SW_SUSPEND);
        dev(1'b1, `LPMC_SELF_CONTROL_REG_ADDR, 16'h0000, s);
        chk(32'(s[`LPMC_H_TMO_BIT]), 32'h1);
        dev(1'b0, `LPMC_SELF_CONTROL_REG_ADDR, 16'h0600, s);
        wait_mode(LPMC_INIT);
        wait_mode(LPMC_RUN);
        dev(1'b1, `LPMC_SELF_CONTROL_REG_ADDR, 16'h0000, s);
        chk(32'(s[15:0]), 32'h0);
        // Sleep pin during software suspend wins; an external reset then ends standby.
        dev(1'b0, `LPMC_SELF_CONTROL_REG_ADDR, 16'h0700, s);
        wait_mode(LPMC_SW_SUSPEND);
        axi_wr(`LPMC_H_CTRL_ADDR, 32'h1);
        wait_mode(LPMC_HW_STANDBY);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        chk(32'(mode), 32'(LPMC_INIT));
        aresetn <= 1'b1;
        wait_mode(LPMC_RUN);
        // Each event kind gives one stretched pulse of the activity LED.
        for (int i = 0; i < 3; i++) begin
            ev <= 3'(1 << i);
            @(posedge aclk);
            ev <= 3'b000;
            @(posedge aclk);
            chk(32'(link.activity_led_n), 32'h0);
            repeat (LED - 2) @(posedge aclk);
            chk(32'(link.activity_led_n), 32'h0);
            repeat (4) @(posedge aclk);
            chk(32'(link.activity_led_n), 32'h1);
        end
        summarize();
    end
    // Watchdog sized well above the few hundred cycles the sequence needs.
    initial begin
        repeat (30000) @(posedge aclk);
        error_cnt++;
        $display("watchdog expired at %0t", $time);
        summarize();
    end
endmodule // tb_low_power_mode_controller
